// *** pkg/cds_ch_if.sv ***
// per-channel bundle between the sequencer, its store and its loop arbiter
`timescale 1ns/100ps
`default_nettype none
interface cds_ch_if;
  logic        host_we;
  logic [6:0]  host_addr;
  logic [15:0] host_wdata;
  logic [15:0] host_rdata;
  logic [6:0]  seq_addr;
  logic [15:0] seq_rdata;
  logic        run;
  logic        cc_sel;
  logic        cv_sel;
  logic        elig;
  logic [14:0] ct;
  logic [14:0] vt;
  logic [14:0] i_meas;
  logic [14:0] v_meas;
  logic        cv_ctrl;
  logic [7:0]  duty;
  modport ctl (output host_we, host_addr, host_wdata, seq_addr, run, cc_sel, cv_sel,
               elig, ct, vt, i_meas, v_meas, input host_rdata, seq_rdata, cv_ctrl, duty);
  modport mem (input host_we, host_addr, host_wdata, seq_addr, output host_rdata, seq_rdata);
  modport loop (input run, cc_sel, cv_sel, elig, ct, vt, i_meas, v_meas,
                output cv_ctrl, duty);
endinterface : cds_ch_if
`default_nettype wire

// *** pkg/cds_pkg.sv ***
// constants and shared types for the charge/discharge sequencer
package cds_pkg;
  // register block bases (word addresses)
  localparam logic [15:0] BASE_SERIAL = 16'h0000;
  localparam logic [15:0] BASE_SYSTEM = 16'h1000;
  localparam logic [15:0] BASE_AUX    = 16'h2800;
  localparam logic [15:0] BASE_CHAN   = 16'h3000;
  localparam logic [15:0] BASE_SEQ    = 16'h3800;
  localparam logic [15:0] CHAN_STRIDE = 16'h0200;
  localparam logic [15:0] BLOCK_END   = 16'h4000;
  localparam int          NUM_CH      = 4;
  localparam int          SEQ_DEPTH   = 128;
  localparam int          SEQ_AW      = 7;
  // per-channel register offsets
  localparam logic [8:0] OFS_CTRL    = 9'h000;
  localparam logic [8:0] OFS_STG_HDR = 9'h001;
  localparam logic [8:0] OFS_STG_W0  = 9'h002;
  localparam logic [8:0] OFS_STATUS  = 9'h00A;
  localparam logic [8:0] OFS_DUTY    = 9'h00B;
  localparam logic [8:0] OFS_LOOP    = 9'h00C;
  // control and status bit positions
  localparam int CTRL_START   = 2;
  localparam int CTRL_STOP    = 3;
  localparam int CTRL_PRELOAD = 4;
  localparam int ST_DONE      = 0;
  localparam int ST_TOUT      = 4;
  // instruction header fields
  localparam int HDR_CV     = 2;
  localparam int HDR_CC     = 3;
  localparam int HDR_NOLIM  = 6;
  localparam int HDR_LSTART = 10;
  localparam int HDR_LEND   = 11;
  localparam int HDR_TMODE  = 15;
  localparam logic [1:0] T_CHARGE = 2'h2;
  localparam logic [1:0] T_DISCH  = 2'h3;
  // payload word indices and relative flag
  localparam int W_CURRENT_TARGET = 0;
  localparam int W_VOLTAGE_TARGET = 1;
  localparam int W_ILIM = 4;
  localparam int W_VLIM = 5;
  localparam int W_TLIM = 6;
  localparam int W_LOOP = 7;
  localparam int REL_BIT = 15;
  // timing
  localparam int         CLK_PERIOD_NS = 20;
  localparam int         TIME_UNIT_NS  = 1000;
  localparam int         TICK_CYC      = TIME_UNIT_NS / CLK_PERIOD_NS;
  localparam logic [5:0] TICK_LAST     = 6'(TICK_CYC - 1);
  // drive and reset values
  localparam logic [7:0]  DUTY_IDLE = 8'h00;
  localparam logic [7:0]  DUTY_MAX  = 8'hFF;
  localparam logic [15:0] WORD_RST  = 16'h0000;

  typedef enum logic [1:0] {
    MODE_MANUAL = 2'b00,
    MODE_SEMI   = 2'b01,
    MODE_AUTO   = 2'b10,
    MODE_RSVD   = 2'b11
  } cds_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_HDR  = 3'b001,
    ST_PAY  = 3'b010,
    ST_LOAD = 3'b011,
    ST_RUN  = 3'b100
  } cds_st_t;
endpackage : cds_pkg

// *** src/cds_loop_arb.sv ***
// constant-current / constant-voltage arbitration and duty integrator
`timescale 1ns/100ps
`default_nettype none
module cds_loop_arb (
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic sys_rst_i,
  // channel bundle
  cds_ch_if.loop    lp
);
  typedef struct packed {
    logic       cv_ctrl;
    logic [7:0] duty;
  } cds_arb_t;

  cds_arb_t           q;
  cds_arb_t           next_q;
  logic signed [15:0] cc_err;
  logic signed [15:0] cv_err;
  logic signed [15:0] err;
  logic               use_cv;

  always_comb
  begin
    cc_err = $signed({1'b0, lp.ct}) - $signed({1'b0, lp.i_meas});
    cv_err = $signed({1'b0, lp.vt}) - $signed({1'b0, lp.v_meas});
    // cv only competes once eligible, then the smaller error wins
    use_cv = lp.cv_sel && (!lp.cc_sel || (lp.elig && (cv_err < cc_err)));
    err    = use_cv ? cv_err : cc_err;
    next_q = q;
    next_q.cv_ctrl = lp.run && use_cv;
    // simple integrator stands in for the filter arithmetic
    if (!lp.run)
    begin
      next_q.duty = cds_pkg::DUTY_IDLE;
    end
    else if ((err > 16'sd0) && (q.duty != cds_pkg::DUTY_MAX))
    begin
      next_q.duty = q.duty + 8'h01;
    end
    else if ((err < 16'sd0) && (q.duty != cds_pkg::DUTY_IDLE))
    begin
      next_q.duty = q.duty - 8'h01;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= next_q;
    end
  end

  assign lp.cv_ctrl = q.cv_ctrl;
  assign lp.duty    = q.duty;
endmodule : cds_loop_arb
`default_nettype wire

// *** src/cds_seq_mem.sv ***
// one channel's 128-word instruction store with host and sequencer read ports
`timescale 1ns/100ps
`default_nettype none
module cds_seq_mem (
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic sys_rst_i,
  // channel bundle
  cds_ch_if.mem     mp
);
  typedef struct packed {
    logic [15:0] host_rdata;
    logic [15:0] seq_rdata;
  } cds_mem_t;

  logic [15:0] store [0:cds_pkg::SEQ_DEPTH-1];
  cds_mem_t    q;
  cds_mem_t    next_q;

  // words only, no control registers in this block
  always_ff @(posedge ref_clk_i)
  begin
    if (mp.host_we)
    begin
      store[mp.host_addr] <= mp.host_wdata;
    end
  end

  always_comb
  begin
    next_q.host_rdata = store[mp.host_addr];
    next_q.seq_rdata  = store[mp.seq_addr];
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= next_q;
    end
  end

  assign mp.host_rdata = q.host_rdata;
  assign mp.seq_rdata  = q.seq_rdata;
endmodule : cds_seq_mem
`default_nettype wire

// *** src/cds_top.sv ***
// four-channel charge/discharge sequencer with register port and pwm drive
`timescale 1ns/100ps
`default_nettype none
module cds_top (
  // clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             sys_rst_i,
  // register port
  input  wire logic [15:0]      reg_addr_i,
  input  wire logic [15:0]      reg_wdata_i,
  input  wire logic             reg_wr_i,
  input  wire logic             reg_rd_i,
  output logic      [15:0]      reg_rdata_o,
  // channel measurements
  input  wire logic [3:0][14:0] i_meas_i,
  input  wire logic [3:0][14:0] v_meas_i,
  // power stage drives
  output logic      [3:0]       high_side_drive_o,
  output logic      [3:0]       low_side_drive_o,
  // per-channel done flags
  output logic      [3:0]       instruction_complete_flag_o
);
  typedef struct packed {
    cds_pkg::cds_st_t   st;
    cds_pkg::cds_mode_t mode;
    logic               pend;
    logic               done;
    logic               tout;
    logic               elig;
    logic               ended;
    logic [15:0]        stg_hdr;
    logic [7:0][15:0]   stg_w;
    logic [15:0]        hdr;
    logic [7:0][15:0]   w;
    logic [7:0]         rem;
    logic [14:0]        vt;
    logic [14:0]        vl;
    logic [7:0]         lcnt;
    logic [6:0]         lpc;
    logic [6:0]         pc;
    logic [6:0]         ipc;
    logic [15:0]        tcnt;
    logic [5:0]         tpre;
  } cds_ch_t;

  typedef struct packed {
    cds_ch_t [3:0] ch;
    logic [15:0]   rdv;
    logic          rdm;
    logic [1:0]    rdc;
    logic [7:0]    pwm_cnt;
    logic [3:0]    hs;
    logic [3:0]    ls;
  } cds_top_t;

  cds_top_t          q;
  cds_top_t          next_q;
  logic              in_chan;
  logic              in_seq;
  logic [1:0]        sel_ch;
  logic [8:0]        off;
  logic [3:0][15:0]  seq_rdata_a;
  logic [3:0][15:0]  host_rdata_a;
  logic [3:0][7:0]   duty_a;
  logic [3:0]        cv_ctrl_a;
  localparam int     CTRL_PRELOAD_BIT = cds_pkg::CTRL_PRELOAD;

  // words present for a given header
  function automatic logic [7:0] word_mask(input logic [15:0] hdr);
    logic [7:0] m;
    m = 8'h00;
    m[cds_pkg::W_CURRENT_TARGET] = hdr[cds_pkg::HDR_CC];
    m[cds_pkg::W_VLIM] = hdr[cds_pkg::HDR_CC];
    m[cds_pkg::W_VOLTAGE_TARGET] = hdr[cds_pkg::HDR_CV];
    m[cds_pkg::W_ILIM] = hdr[cds_pkg::HDR_CV];
    m[cds_pkg::W_TLIM] = 1'b1;
    m[cds_pkg::W_LOOP] = hdr[cds_pkg::HDR_LSTART];
    return m;
  endfunction : word_mask

  function automatic logic [2:0] lowest(input logic [7:0] rem);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 7; i >= 0; i--)
    begin
      if (rem[i])
      begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction : lowest

  // staged words with absent positions cleared
  function automatic logic [7:0][15:0] masked(input logic [15:0] hdr,
                                              input logic [7:0][15:0] w);
    logic [7:0][15:0] o;
    logic [7:0]       m;
    m = word_mask(hdr);
    for (int i = 0; i < 8; i++)
    begin
      o[i] = m[i] ? w[i] : cds_pkg::WORD_RST;
    end
    return o;
  endfunction : masked

  // block decode; serial, system and aux blocks live elsewhere and read zero
  assign in_chan = (reg_addr_i >= cds_pkg::BASE_CHAN) && (reg_addr_i < cds_pkg::BASE_SEQ);
  assign in_seq  = (reg_addr_i >= cds_pkg::BASE_SEQ) && (reg_addr_i < cds_pkg::BLOCK_END);
  assign sel_ch  = reg_addr_i[10:9];
  assign off     = reg_addr_i[8:0];

  genvar g;
  generate
    for (g = 0; g < cds_pkg::NUM_CH; g++)
    begin : g_ch
      cds_ch_if chif ();
      assign chif.host_we    = reg_wr_i && in_seq && (sel_ch == 2'(g)) && (off[8:7] == 2'b00);
      assign chif.host_addr  = off[6:0];
      assign chif.host_wdata = reg_wdata_i;
      assign chif.seq_addr   = next_q.ch[g].pc;
      assign chif.run        = (q.ch[g].st == cds_pkg::ST_RUN);
      assign chif.cc_sel     = q.ch[g].hdr[cds_pkg::HDR_CC];
      assign chif.cv_sel     = q.ch[g].hdr[cds_pkg::HDR_CV];
      assign chif.elig       = q.ch[g].elig;
      assign chif.ct         = q.ch[g].w[cds_pkg::W_CURRENT_TARGET][14:0];
      assign chif.vt         = q.ch[g].vt;
      assign chif.i_meas     = i_meas_i[g];
      assign chif.v_meas     = v_meas_i[g];
      assign seq_rdata_a[g]  = chif.seq_rdata;
      assign host_rdata_a[g] = chif.host_rdata;
      assign duty_a[g]       = chif.duty;
      assign cv_ctrl_a[g]    = chif.cv_ctrl;
      cds_seq_mem u_mem (
        .ref_clk_i (ref_clk_i),
        .sys_rst_i (sys_rst_i),
        .mp        (chif)
      );
      cds_loop_arb u_arb (
        .ref_clk_i (ref_clk_i),
        .sys_rst_i (sys_rst_i),
        .lp        (chif)
      );
    end
  endgenerate

  always_comb
  begin
    cds_ch_t    c;
    logic [7:0] m;
    logic [2:0] idx;
    logic       set_d;
    logic       set_t;
    logic       clr_d;
    logic       clr_t;
    logic       tick;
    logic       lim_t;
    logic       endc;
    logic       wr_ch;
    c      = '0;
    m      = 8'h00;
    idx    = 3'h0;
    set_d  = 1'b0;
    set_t  = 1'b0;
    clr_d  = 1'b0;
    clr_t  = 1'b0;
    tick   = 1'b0;
    lim_t  = 1'b0;
    endc   = 1'b0;
    wr_ch  = 1'b0;
    next_q = q;
    next_q.pwm_cnt = q.pwm_cnt + 8'h01;
    // read answer is captured now and shown next cycle only
    next_q.rdm = 1'b0;
    next_q.rdv = cds_pkg::WORD_RST;
    next_q.rdc = sel_ch;
    if (reg_rd_i)
    begin
      c = q.ch[sel_ch];
      if (in_seq)
      begin
        next_q.rdm = (off[8:7] == 2'b00);
      end
      else if (!in_chan)
      begin
        next_q.rdv = cds_pkg::WORD_RST;
      end
      else if (off == cds_pkg::OFS_CTRL)
      begin
        next_q.rdv = {14'h0000, c.mode};
      end
      else if (off == cds_pkg::OFS_STG_HDR)
      begin
        next_q.rdv = c.stg_hdr;
      end
      else if ((off >= cds_pkg::OFS_STG_W0) && (off < cds_pkg::OFS_STATUS))
      begin
        next_q.rdv = c.stg_w[3'(off - cds_pkg::OFS_STG_W0)];
      end
      else if (off == cds_pkg::OFS_STATUS)
      begin
        next_q.rdv = {10'h000, c.elig, c.tout, c.pend, cv_ctrl_a[sel_ch],
                      (c.st != cds_pkg::ST_IDLE), c.done};
      end
      else if (off == cds_pkg::OFS_DUTY)
      begin
        next_q.rdv = {8'h00, duty_a[sel_ch]};
      end
      else if (off == cds_pkg::OFS_LOOP)
      begin
        next_q.rdv = {1'b0, c.pc, c.lcnt};
      end
    end

    for (int k = 0; k < cds_pkg::NUM_CH; k++)
    begin
      c     = q.ch[k];
      set_d = 1'b0;
      set_t = 1'b0;
      clr_d = 1'b0;
      clr_t = 1'b0;
      tick  = 1'b0;
      lim_t = 1'b0;
      endc  = 1'b0;
      m     = word_mask(seq_rdata_a[k]);
      idx   = lowest(c.rem);
      wr_ch = reg_wr_i && in_chan && (sel_ch == 2'(k));
      case (c.st)
        cds_pkg::ST_HDR:
        begin
          c.hdr = seq_rdata_a[k];
          c.w   = '0;
          c.ipc = c.pc;
          c.pc  = c.pc + 7'h01;
          c.rem = m;
          c.st  = (m == 8'h00) ? cds_pkg::ST_LOAD : cds_pkg::ST_PAY;
        end
        cds_pkg::ST_PAY:
        begin
          c.w[idx]   = seq_rdata_a[k];
          c.rem[idx] = 1'b0;
          c.pc       = c.pc + 7'h01;
          if (c.rem == 8'h00)
          begin
            c.st = cds_pkg::ST_LOAD;
          end
        end
        cds_pkg::ST_LOAD:
        begin
          // relative levels are frozen against the measurement at load time
          c.vt = c.w[cds_pkg::W_VOLTAGE_TARGET][cds_pkg::REL_BIT] ?
                 15'(v_meas_i[k] + c.w[cds_pkg::W_VOLTAGE_TARGET][14:0]) :
                 c.w[cds_pkg::W_VOLTAGE_TARGET][14:0];
          c.vl = c.w[cds_pkg::W_VLIM][cds_pkg::REL_BIT] ?
                 15'(v_meas_i[k] + c.w[cds_pkg::W_VLIM][14:0]) :
                 c.w[cds_pkg::W_VLIM][14:0];
          if (c.hdr[cds_pkg::HDR_LSTART])
          begin
            c.lpc = c.ipc;
            if (c.lcnt == 8'h00)
            begin
              c.lcnt = c.w[cds_pkg::W_LOOP][7:0];
            end
          end
          c.tcnt  = 16'h0000;
          c.tpre  = 6'h00;
          c.ended = 1'b0;
          c.elig  = ~c.hdr[cds_pkg::HDR_CC];
          // halt, rest and anything else stop the channel with drives low
          if ((c.hdr[1:0] == cds_pkg::T_CHARGE) || (c.hdr[1:0] == cds_pkg::T_DISCH))
          begin
            c.st = cds_pkg::ST_RUN;
          end
          else
          begin
            c.st = cds_pkg::ST_IDLE;
          end
        end
        cds_pkg::ST_RUN:
        begin
          tick   = (c.tpre == cds_pkg::TICK_LAST);
          c.tpre = tick ? 6'h00 : c.tpre + 6'h01;
          if (tick && (c.tcnt != 16'hFFFF))
          begin
            c.tcnt = c.tcnt + 16'h0001;
          end
          if (v_meas_i[k] > c.vl)
          begin
            c.elig = 1'b1;
          end
          lim_t = (c.w[cds_pkg::W_TLIM] != 16'h0000) && (q.ch[k].tcnt >= c.w[cds_pkg::W_TLIM]);
          set_t = lim_t && c.hdr[cds_pkg::HDR_TMODE];
          endc  = (lim_t && !c.hdr[cds_pkg::HDR_TMODE]) ||
                  (!c.hdr[cds_pkg::HDR_NOLIM] &&
                   ((c.hdr[cds_pkg::HDR_CV] && q.ch[k].elig &&
                     (i_meas_i[k] <= c.w[cds_pkg::W_ILIM][14:0])) ||
                    (c.hdr[cds_pkg::HDR_CC] && !c.hdr[cds_pkg::HDR_CV] &&
                     (v_meas_i[k] > c.vl))));
          if (endc && !c.ended)
          begin
            case (c.mode)
              cds_pkg::MODE_MANUAL:
              begin
                set_d   = 1'b1;
                c.ended = 1'b1;
              end
              cds_pkg::MODE_SEMI:
              begin
                set_d = 1'b1;
                if (c.pend)
                begin
                  c.hdr  = c.stg_hdr;
                  c.w    = masked(c.stg_hdr, c.stg_w);
                  c.pend = 1'b0;
                  c.st   = cds_pkg::ST_LOAD;
                end
                else
                begin
                  c.ended = 1'b1;
                end
              end
              default:
              begin
                if (c.hdr[cds_pkg::HDR_LEND] && (c.lcnt != 8'h00))
                begin
                  c.lcnt = c.lcnt - 8'h01;
                  if (c.lcnt != 8'h00)
                  begin
                    c.pc = c.lpc;
                  end
                end
                c.st = cds_pkg::ST_HDR;
              end
            endcase
          end
        end
        default:
        begin
          c.st = cds_pkg::ST_IDLE;
        end
      endcase

      // host writes take priority over the sequencer's own moves, except a done or timeout set
      if (wr_ch && (off == cds_pkg::OFS_CTRL))
      begin
        c.mode = cds_pkg::cds_mode_t'(reg_wdata_i[1:0]);
        if (reg_wdata_i[CTRL_PRELOAD_BIT])
        begin
          c.pend = 1'b1;
        end
        if (reg_wdata_i[cds_pkg::CTRL_STOP])
        begin
          c.st = cds_pkg::ST_IDLE;
        end
        else if (reg_wdata_i[cds_pkg::CTRL_START])
        begin
          if (reg_wdata_i[1:0] == cds_pkg::MODE_AUTO)
          begin
            c.pc   = 7'h00;
            c.lcnt = 8'h00;
            c.st   = cds_pkg::ST_HDR;
          end
          else
          begin
            c.hdr = c.stg_hdr;
            c.w   = masked(c.stg_hdr, c.stg_w);
            c.st  = cds_pkg::ST_LOAD;
          end
        end
      end
      else if (wr_ch && (off == cds_pkg::OFS_STG_HDR))
      begin
        c.stg_hdr = reg_wdata_i;
      end
      else if (wr_ch && (off >= cds_pkg::OFS_STG_W0) && (off < cds_pkg::OFS_STATUS))
      begin
        c.stg_w[3'(off - cds_pkg::OFS_STG_W0)] = reg_wdata_i;
      end
      else if (wr_ch && (off == cds_pkg::OFS_STATUS))
      begin
        clr_d = reg_wdata_i[cds_pkg::ST_DONE];
        clr_t = reg_wdata_i[cds_pkg::ST_TOUT];
      end
      // a set in the clearing cycle wins
      c.done = (q.ch[k].done & ~clr_d) | set_d;
      c.tout = (q.ch[k].tout & ~clr_t) | set_t;
      next_q.ch[k] = c;
      next_q.hs[k] = (q.ch[k].st == cds_pkg::ST_RUN) && (q.pwm_cnt < duty_a[k]);
      next_q.ls[k] = (q.ch[k].st == cds_pkg::ST_RUN) && !(q.pwm_cnt < duty_a[k]);
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= next_q;
    end
  end

  assign reg_rdata_o                 = q.rdm ? host_rdata_a[q.rdc] : q.rdv;
  assign high_side_drive_o           = q.hs;
  assign low_side_drive_o            = q.ls;
  assign instruction_complete_flag_o = {q.ch[3].done, q.ch[2].done, q.ch[1].done, q.ch[0].done};
endmodule : cds_top
`default_nettype wire

// *** verification/cds_plant.sv ***
// battery stand-in: voltage climbs per high-side cycle, current stays zero
`timescale 1ns/100ps
`default_nettype none
module cds_plant (
  // clock and preset
  input  wire logic             ref_clk_i,
  input  wire logic             load_i,
  input  wire logic [14:0]      v_start_i,
  // drives in, measurements out
  input  wire logic [3:0]       high_side_drive_i,
  output logic      [3:0][14:0] i_meas_o,
  output logic      [3:0][14:0] v_meas_o
);
  // zero current keeps the current loop asking for more duty
  assign i_meas_o = 60'h0;
  always_ff @(posedge ref_clk_i)
    for (int k = 0; k < 4; k++)
      v_meas_o[k] <= load_i ? v_start_i : v_meas_o[k] + 15'(high_side_drive_i[k]);
endmodule : cds_plant
`default_nettype wire

// *** verification/cds_properties.sv ***
// port assertions for the sequencer top
`timescale 1ns/100ps
`default_nettype none
module cds_properties (
  // clock and reset
  input wire logic        ref_clk_i,
  input wire logic        sys_rst_i,
  // register port
  input wire logic [15:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  // drives and flags
  input wire logic [3:0]  high_side_drive_o,
  input wire logic [3:0]  low_side_drive_o,
  input wire logic [3:0]  instruction_complete_flag_o
);
  wire logic dn;
  wire logic sto;
  wire logic stg;
  // channel 0 stands for all four, they share one layout
  assign dn  = instruction_complete_flag_o[0];
  assign sto = reg_addr_i[15:11] == 5'h07;
  assign stg = reg_addr_i[15:11] == 5'h06 && reg_addr_i[8:0] == 9'h001;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  property p_ovl; (high_side_drive_o & low_side_drive_o) == 4'h0; endproperty
  a_ovl: assert property (p_ovl) else $error("drive overlap");
  property p_hold; dn && !reg_wr_i |=> dn; endproperty
  a_hold: assert property (p_hold) else $error("done lost");
  property p_clr; reg_wr_i && reg_addr_i == 16'h300A && reg_wdata_i[0] |=> !dn; endproperty
  a_clr: assert property (p_clr) else $error("done kept");
  property p_gap; reg_rd_i && reg_addr_i < 16'h3000 |=> reg_rdata_o == 16'h0000; endproperty
  a_gap: assert property (p_gap) else $error("unmapped read");
  property p_hole; reg_rd_i && sto && reg_addr_i[8:7] != 2'h0 |=> reg_rdata_o == 16'h0000;
  endproperty
  a_hole: assert property (p_hole) else $error("hole read");
  property p_sto;
    reg_wr_i && sto && reg_addr_i[8:7] == 2'h0 ##2 reg_rd_i && reg_addr_i == $past(reg_addr_i, 2)
    |=> reg_rdata_o == $past(reg_wdata_i, 3);
  endproperty
  a_sto: assert property (p_sto) else $error("store read");
  property p_stg;
    reg_wr_i && stg ##2 reg_rd_i && reg_addr_i == $past(reg_addr_i, 2)
    |=> reg_rdata_o == $past(reg_wdata_i, 3);
  endproperty
  a_stg: assert property (p_stg) else $error("staged read");
  property p_stop;
    reg_wr_i && reg_addr_i == 16'h3000 && reg_wdata_i[3]
    |-> ##[1:3] (high_side_drive_o[0] == 1'b0 && low_side_drive_o[0] == 1'b0);
  endproperty
  a_stop: assert property (p_stop) else $error("drive after stop");
endmodule : cds_properties
bind cds_top cds_properties u_props (.ref_clk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i,
  .reg_wr_i, .reg_rd_i, .reg_rdata_o, .high_side_drive_o, .low_side_drive_o,
  .instruction_complete_flag_o);
`default_nettype wire

// *** verification/tb_top.sv ***
// bench: map, manual, semi and auto sequencing
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic             ref_clk_i;
  logic             sys_rst_i;
  logic [15:0]      reg_addr_i;
  logic [15:0]      reg_wdata_i;
  logic             reg_wr_i;
  logic             reg_rd_i;
  logic [15:0]      reg_rdata_o;
  logic [3:0][14:0] im;
  logic [3:0][14:0] vm;
  logic [3:0]       hi;
  logic [3:0]       lo;
  logic [3:0]       done;
  logic             ld;
  logic [14:0]      v0;
  logic [15:0]      a, q, h;
  logic [15:0]      prog [6];
  logic [15:0]      mdl [int];
  int               n_errors, checks_done, cyc;
  cds_top u_dut (.ref_clk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .i_meas_i(im), .v_meas_i(vm), .high_side_drive_o(hi),
    .low_side_drive_o(lo), .instruction_complete_flag_o(done));
  cds_plant u_plant (.ref_clk_i, .load_i(ld), .v_start_i(v0), .high_side_drive_i(hi),
    .i_meas_o(im), .v_meas_o(vm));
  initial
  begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      conclude();
    end
  end
  task automatic wr(input logic [15:0] aw, input logic [15:0] dw);
    {reg_addr_i, reg_wdata_i, reg_wr_i} <= {aw, dw, 1'b1};
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask : wr
  task automatic rd(input logic [15:0] ar, output logic [15:0] dr);
    {reg_addr_i, reg_rd_i} <= {ar, 1'b1};
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1 dr = reg_rdata_o;
    @(posedge ref_clk_i);
  endtask : rd
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic load_v();
    {ld, v0} <= {1'b1, 15'h0200 + 15'($urandom_range(1023))};
    @(posedge ref_clk_i);
    ld <= 1'b0;
    @(posedge ref_clk_i);
  endtask : load_v
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude
  initial
  begin
    {sys_rst_i, ld, reg_wr_i, reg_rd_i} = 4'hC;
    {reg_addr_i, reg_wdata_i, v0} = 47'h0;
    void'($urandom(32'h2A2D));
    repeat (20) @(posedge ref_clk_i);
    {sys_rst_i, ld} <= 2'h0;
    @(posedge ref_clk_i);
    for (int k = 0; k < 4; k++)
    begin
      a = 16'h3800 + 16'(k) * 16'h0200 + 16'($urandom_range(127));
      mdl[a] = 16'($urandom);
      wr(a, mdl[a]);
      rd(a, q);
      chk("store", q, mdl[a]);
      rd(a | 16'h0080, q);
      chk("hole", q, 16'h0000);
      rd(16'($urandom_range(32'h2FFF)), q);
      chk("unmapped", q, 16'h0000);
      wr({5'h06, a[10:9], 9'h001}, ~mdl[a]);
      rd({5'h06, a[10:9], 9'h001}, q);
      chk("staged", q, ~mdl[a]);
    end
    foreach (mdl[x])
    begin
      rd(16'(x), q);
      chk("kept", q, mdl[x]);
    end
    $display("map test done");
    // mode 0 absolute end level, mode 1 relative one; no preload so both keep running
    for (int m = 0; m < 2; m++)
    begin
      load_v();
      wr(16'h3001, 16'h000A);
      wr(16'h3002, 16'($urandom_range(32767, 1000)));
      wr(16'h3007, m ? 16'h80C8 : {1'b0, v0 + 15'h00C8});
      wr(16'h3008, 16'h0000);
      wr(16'h3000, 16'(m) | 16'h0004);
      for (int n = 0; n < 3000 && done[0] !== 1'b1; n++)
        @(negedge ref_clk_i);
      chk("done", {15'h0000, done[0]}, 16'h0001);
      chk("late", {15'h0000, vm[0] > v0 + 15'h00C8}, 16'h0001);
      chk("early", {15'h0000, vm[0] < v0 + 15'h00D0}, 16'h0001);
      h = 16'h0000;
      repeat (512)
      begin
        @(negedge ref_clk_i);
        h = h + 16'(hi[0]);
      end
      @(posedge ref_clk_i);
      chk("running", {15'h0000, h > 16'h0010}, 16'h0001);
      rd(16'h300A, q);
      chk("status", q & 16'h0003, 16'h0003);
      wr(16'h300A, 16'h0001);
      chk("cleared", {15'h0000, done[0]}, 16'h0000);
      wr(16'h3000, 16'h0008);
      repeat (2) @(posedge ref_clk_i);
      chk("stopped", {14'h0000, hi[0], lo[0]}, 16'h0000);
      $display("mode %0d test done", m);
    end
    // semi with preload: the staged copy runs again, relative to its own start level
    load_v();
    wr(16'h3007, 16'h80C8);
    wr(16'h3000, 16'h0015);
    q = 16'h0008;
    for (int n = 0; n < 1000 && q[3] !== 1'b0; n++)
      rd(16'h300A, q);
    chk("pending", {15'h0000, q[3]}, 16'h0000);
    wr(16'h300A, 16'h0001);
    for (int n = 0; n < 3000 && done[0] !== 1'b1; n++)
      @(negedge ref_clk_i);
    chk("preload", {15'h0000, vm[0] - v0 > 15'h0191}, 16'h0001);
    wr(16'h3000, 16'h0008);
    wr(16'h300A, 16'h0001);
    $display("preload test done");
    // looped charge twice, each pass ends 200 steps above its own start level
    prog = '{16'h0C0A, 16'h1000, 16'h80C8, 16'h0000, 16'h0002, 16'h0000};
    for (int j = 0; j < 6; j++)
      wr(16'h3800 + 16'(j), prog[j]);
    load_v();
    wr(16'h3000, 16'h0006);
    q = 16'h0002;
    for (int n = 0; n < 1000 && q[1] !== 1'b0; n++)
      rd(16'h300A, q);
    chk("passes", {15'h0000, vm[0] - v0 > 15'h0191 && vm[0] - v0 < 15'h01A4}, 16'h0001);
    chk("auto done", {15'h0000, done[0]}, 16'h0000);
    rd(16'h300C, q);
    chk("loop count", q & 16'h00FF, 16'h0000);
    $display("auto test done");
    conclude();
  end
endmodule : tb_top
`default_nettype wire
